// File: rtl/ctt_defines.vh
// Opcode, field and timing constants for the transfer and trap unit
`ifndef CTT_DEFINES_VH
`define CTT_DEFINES_VH

// Opcodes
`define CTT_OP_SOFTWARE_TRAP 16'h3720
`define CTT_OP_BYTE_SIGN_WIDEN 16'h27f8
`define CTT_OP_A_TO_B 16'h3717
`define CTT_OP_A_TO_FLAGS 16'h37fd
`define CTT_OP_B_TO_A 16'h3707
`define CTT_OP_B_TO_EXT_BANK 16'h27fa
`define CTT_OP_B_TO_STACK_BANK 16'h379f
`define CTT_OP_B_TO_X_BANK 16'h379c
`define CTT_OP_B_TO_Y_BANK 16'h379d
`define CTT_OP_B_TO_Z_BANK 16'h379e
`define CTT_OP_D_TO_E 16'h277b
`define CTT_OP_MODULO_MASK_LOAD 16'h372f
`define CTT_OP_WORD_TO_FLAGS 16'h372d
`define CTT_OP_E_TO_D 16'h27fb
`define CTT_OP_PAIR_TO_MAC 16'h27b1
`define CTT_OP_EXT_BANK_TO_B 16'h27bb
`define CTT_OP_HIGH_WORD_TO_MAC 16'h27b2
`define CTT_OP_ROUNDED_MAC_OUT 16'h27b4

// Cycle counts
`define CTT_CYC_TRAP 5'd16
`define CTT_CYC_SHORT 5'd2
`define CTT_CYC_FLAGS 5'd4
`define CTT_CYC_MAC_IN 5'd4
`define CTT_CYC_MAC_OUT 5'd6
`define CTT_CYC_NONE 5'd0

// Trap step numbers, counted from the accepting edge
`define CTT_STEP_PUSH_PC 5'd1
`define CTT_STEP_PUSH_FLAGS 5'd2

// Condition code word bit positions
`define CTT_CC_S 15
`define CTT_CC_MV 14
`define CTT_CC_H 13
`define CTT_CC_EV 12
`define CTT_CC_N 11
`define CTT_CC_Z 10
`define CTT_CC_V 9
`define CTT_CC_C 8
`define CTT_CC_SM 4
`define CTT_CC_PK_HI 3
`define CTT_CC_PK_LO 0

// Arithmetic constants
`define CTT_PC_STEP 20'h00002
`define CTT_ROUND_HALF 36'h000008000
`define CTT_SAT_POS 16'h7fff
`define CTT_SAT_NEG 16'h8000
`define CTT_BYTE_ONES 8'hff
`define CTT_BYTE_ZERO 8'h00
`define CTT_WORD_ZERO 16'h0000
`define CTT_NIB_ZERO 4'h0
`define CTT_BANK_ZERO 4'h0

// Reset values
`define CTT_RST_WORD 16'h0000
`define CTT_RST_MAC 36'h000000000
`define CTT_RST_FLAGS 16'h0000

`endif

// File: rtl/ctt_transfer_trap.v
// Transfer, sign widen, MAC move and software trap execution unit
`timescale 1ns/1ps
`include "ctt_defines.vh"
module ctt_transfer_trap (
	input wire I_SYS_CLK,
	input wire I_RESET,
	input wire I_OP_VALID,
	input wire [15:0] I_OP_CODE,
	input wire [15:0] I_TRAP_VECTOR,
	output wire O_OP_READY,
	output reg O_OP_UNKNOWN,
	output reg O_DONE,
	output reg O_PUSH_VALID,
	output reg [19:0] O_PUSH_ADDR,
	output reg [15:0] O_PUSH_DATA,
	output wire [15:0] O_ACC_D,
	output wire [15:0] O_ACC_E,
	output wire [35:0] O_MAC,
	output wire [15:0] O_FLAGS,
	output wire [3:0] O_PK,
	output wire [15:0] O_PC,
	output wire [3:0] O_SK,
	output wire [15:0] O_SP,
	output wire [3:0] O_EK,
	output wire [3:0] O_XK,
	output wire [3:0] O_YK,
	output wire [3:0] O_ZK,
	output wire [7:0] O_X_MODULO_MASK,
	output wire [7:0] O_Y_MODULO_MASK
);

////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'b01;
localparam ST_EXEC = 2'b10;

reg [1:0] state_q;
reg [15:0] op_q;
reg [4:0] step_q;
reg [4:0] last_q;
reg [7:0] acc_a_q;
reg [7:0] acc_b_q;
reg [15:0] acc_e_q;
reg [35:0] mac_q;
reg [15:0] ccr_q;
reg [15:0] pc_q;
reg [3:0] sk_q;
reg [15:0] sp_q;
reg [3:0] ek_q;
reg [3:0] xk_q;
reg [3:0] yk_q;
reg [3:0] zk_q;
reg [7:0] x_modulo_mask_q;
reg [7:0] y_modulo_mask_q;

// Cycle count per opcode; zero marks an opcode this unit does not own
function [4:0] op_cycles;
	input [15:0] op;
	begin
		case (op)
		`CTT_OP_SOFTWARE_TRAP: op_cycles = `CTT_CYC_TRAP;
		`CTT_OP_A_TO_FLAGS, `CTT_OP_WORD_TO_FLAGS: op_cycles = `CTT_CYC_FLAGS;
		`CTT_OP_PAIR_TO_MAC, `CTT_OP_HIGH_WORD_TO_MAC:
			op_cycles = `CTT_CYC_MAC_IN;
		`CTT_OP_ROUNDED_MAC_OUT: op_cycles = `CTT_CYC_MAC_OUT;
		`CTT_OP_BYTE_SIGN_WIDEN, `CTT_OP_A_TO_B, `CTT_OP_B_TO_A,
		`CTT_OP_B_TO_EXT_BANK, `CTT_OP_B_TO_STACK_BANK, `CTT_OP_B_TO_X_BANK,
		`CTT_OP_B_TO_Y_BANK, `CTT_OP_B_TO_Z_BANK, `CTT_OP_D_TO_E,
		`CTT_OP_MODULO_MASK_LOAD, `CTT_OP_E_TO_D, `CTT_OP_EXT_BANK_TO_B:
			op_cycles = `CTT_CYC_SHORT;
		default: op_cycles = `CTT_CYC_NONE;
		endcase
	end
endfunction

// Flags word with N and Z taken from a 16-bit result
function [15:0] set_nz16;
	input [15:0] flags;
	input [15:0] val;
	reg [15:0] f;
	begin
		f = flags;
		f[`CTT_CC_N] = val[15];
		f[`CTT_CC_Z] = (val == `CTT_WORD_ZERO);
		set_nz16 = f;
	end
endfunction

// Flags word with N and Z from a byte result and V cleared
function [15:0] set_nz8v;
	input [15:0] flags;
	input [7:0] val;
	reg [15:0] f;
	begin
		f = flags;
		f[`CTT_CC_N] = val[7];
		f[`CTT_CC_Z] = (val == `CTT_BYTE_ZERO);
		f[`CTT_CC_V] = 1'b0;
		set_nz8v = f;
	end
endfunction

////////////////////////////////////////////////////////////////////////////
wire [4:0] new_cycles = op_cycles(I_OP_CODE);
wire idle = state_q[0];
wire accept = idle & I_OP_VALID & (new_cycles != `CTT_CYC_NONE);
wire finish = state_q[1] & (step_q == last_q);
wire [15:0] acc_d = {acc_a_q, acc_b_q};
wire [19:0] ret_addr = {ccr_q[`CTT_CC_PK_HI:`CTT_CC_PK_LO], pc_q}
	+ `CTT_PC_STEP;
wire [19:0] stack_addr = {sk_q, sp_q};
wire [19:0] stack_next = stack_addr - `CTT_PC_STEP;
// Round half up into bit 16
wire [35:0] mac_round = mac_q + `CTT_ROUND_HALF;
// Overflow out of the 36-bit accumulator sign
wire round_mv = ~mac_q[35] & mac_round[35];
// Bits 35..31 disagree: value no longer fits 32 bits
wire round_ev = ~((&mac_round[35:31]) | ~(|mac_round[35:31]));
wire round_sat = ccr_q[`CTT_CC_SM] & (round_mv | round_ev);
wire [15:0] sat_val = mac_q[35] ? `CTT_SAT_NEG : `CTT_SAT_POS;
wire [15:0] round_word = round_sat ? sat_val : mac_round[31:16];

assign O_OP_READY = idle;
assign O_ACC_D = acc_d;
assign O_ACC_E = acc_e_q;
assign O_MAC = mac_q;
assign O_FLAGS = ccr_q;
assign O_PK = ccr_q[`CTT_CC_PK_HI:`CTT_CC_PK_LO];
assign O_PC = pc_q;
assign O_SK = sk_q;
assign O_SP = sp_q;
assign O_EK = ek_q;
assign O_XK = xk_q;
assign O_YK = yk_q;
assign O_ZK = zk_q;
assign O_X_MODULO_MASK = x_modulo_mask_q;
assign O_Y_MODULO_MASK = y_modulo_mask_q;

////////////////////////////////////////////////////////////////////////////
always @(posedge I_SYS_CLK or posedge I_RESET) begin
	if (I_RESET) begin
		state_q <= ST_IDLE;
		op_q <= `CTT_RST_WORD;
		step_q <= `CTT_CYC_NONE;
		last_q <= `CTT_CYC_NONE;
		O_OP_UNKNOWN <= 1'b0;
		O_DONE <= 1'b0;
		O_PUSH_VALID <= 1'b0;
		O_PUSH_ADDR <= {`CTT_BANK_ZERO, `CTT_RST_WORD};
		O_PUSH_DATA <= `CTT_RST_WORD;
		acc_a_q <= `CTT_BYTE_ZERO;
		acc_b_q <= `CTT_BYTE_ZERO;
		acc_e_q <= `CTT_RST_WORD;
		mac_q <= `CTT_RST_MAC;
		ccr_q <= `CTT_RST_FLAGS;
		pc_q <= `CTT_RST_WORD;
		sk_q <= `CTT_BANK_ZERO;
		sp_q <= `CTT_RST_WORD;
		ek_q <= `CTT_BANK_ZERO;
		xk_q <= `CTT_BANK_ZERO;
		yk_q <= `CTT_BANK_ZERO;
		zk_q <= `CTT_BANK_ZERO;
		x_modulo_mask_q <= `CTT_BYTE_ZERO;
		y_modulo_mask_q <= `CTT_BYTE_ZERO;
	end else begin
		O_OP_UNKNOWN <= idle & I_OP_VALID & (new_cycles == `CTT_CYC_NONE);
		O_DONE <= finish;
		O_PUSH_VALID <= 1'b0;
		case (state_q)
		ST_IDLE: begin
			if (accept) begin
				state_q <= ST_EXEC;
				op_q <= I_OP_CODE;
				step_q <= 5'd1;
				last_q <= new_cycles - 5'd1;
				if (I_OP_CODE == `CTT_OP_SOFTWARE_TRAP) begin
					ccr_q[`CTT_CC_PK_HI:`CTT_CC_PK_LO] <= ret_addr[19:16];
					pc_q <= ret_addr[15:0];
				end
			end
		end
		ST_EXEC: begin
			step_q <= step_q + 5'd1;
			if (op_q == `CTT_OP_SOFTWARE_TRAP) begin
				if (step_q == `CTT_STEP_PUSH_PC) begin
					O_PUSH_VALID <= 1'b1;
					O_PUSH_ADDR <= stack_addr;
					O_PUSH_DATA <= pc_q;
					{sk_q, sp_q} <= stack_next;
				end
				if (step_q == `CTT_STEP_PUSH_FLAGS) begin
					O_PUSH_VALID <= 1'b1;
					O_PUSH_ADDR <= stack_addr;
					O_PUSH_DATA <= ccr_q;
					{sk_q, sp_q} <= stack_next;
				end
			end
			if (finish) begin
				state_q <= ST_IDLE;
				case (op_q)
				`CTT_OP_SOFTWARE_TRAP: begin
					ccr_q[`CTT_CC_PK_HI:`CTT_CC_PK_LO] <= `CTT_BANK_ZERO;
					pc_q <= I_TRAP_VECTOR;
				end
				`CTT_OP_BYTE_SIGN_WIDEN: begin
					acc_a_q <= acc_b_q[7] ? `CTT_BYTE_ONES : `CTT_BYTE_ZERO;
					ccr_q <= set_nz16(ccr_q, {{8{acc_b_q[7]}}, acc_b_q});
				end
				`CTT_OP_MODULO_MASK_LOAD: begin
					x_modulo_mask_q <= acc_d[15:8];
					y_modulo_mask_q <= acc_d[7:0];
				end
				`CTT_OP_PAIR_TO_MAC: begin
					mac_q <= {{4{acc_e_q[15]}}, acc_e_q, acc_d};
					ccr_q[`CTT_CC_MV] <= 1'b0;
					ccr_q[`CTT_CC_EV] <= 1'b0;
				end
				`CTT_OP_HIGH_WORD_TO_MAC: begin
					mac_q <= {{4{acc_e_q[15]}}, acc_e_q, `CTT_WORD_ZERO};
					ccr_q[`CTT_CC_MV] <= 1'b0;
					ccr_q[`CTT_CC_EV] <= 1'b0;
				end
				`CTT_OP_ROUNDED_MAC_OUT: begin
					acc_e_q <= round_word;
					ccr_q <= set_nz16({ccr_q[15] , round_mv, ccr_q[13],
						round_ev, ccr_q[11:0]}, round_word);
				end
				`CTT_OP_A_TO_B: begin
					acc_b_q <= acc_a_q;
					ccr_q <= set_nz8v(ccr_q, acc_a_q);
				end
				`CTT_OP_B_TO_A: begin
					acc_a_q <= acc_b_q;
					ccr_q <= set_nz8v(ccr_q, acc_b_q);
				end
				`CTT_OP_D_TO_E: begin
					acc_e_q <= acc_d;
					ccr_q <= set_nz8v(ccr_q, acc_d[15:8]);
					ccr_q[`CTT_CC_N] <= acc_d[15];
					ccr_q[`CTT_CC_Z] <= (acc_d == `CTT_WORD_ZERO);
				end
				`CTT_OP_E_TO_D: begin
					{acc_a_q, acc_b_q} <= acc_e_q;
					ccr_q <= set_nz8v(ccr_q, acc_e_q[15:8]);
					ccr_q[`CTT_CC_N] <= acc_e_q[15];
					ccr_q[`CTT_CC_Z] <= (acc_e_q == `CTT_WORD_ZERO);
				end
				`CTT_OP_A_TO_FLAGS: ccr_q[15:8] <= acc_a_q;
				`CTT_OP_WORD_TO_FLAGS:
					ccr_q[15:4] <= acc_d[15:4];
				`CTT_OP_B_TO_EXT_BANK: ek_q <= acc_b_q[3:0];
				`CTT_OP_B_TO_STACK_BANK: sk_q <= acc_b_q[3:0];
				`CTT_OP_B_TO_X_BANK: xk_q <= acc_b_q[3:0];
				`CTT_OP_B_TO_Y_BANK: yk_q <= acc_b_q[3:0];
				`CTT_OP_B_TO_Z_BANK: zk_q <= acc_b_q[3:0];
				`CTT_OP_EXT_BANK_TO_B: acc_b_q <= {`CTT_NIB_ZERO, ek_q};
				default: state_q <= ST_IDLE;
				endcase
			end
		end
		default: state_q <= ST_IDLE;
		endcase
	end
end

endmodule // ctt_transfer_trap

// File: dv/ctt_transfer_trap_asserts.sv
// Timing and result checks on the transfer and trap unit ports
`timescale 1ns/1ps
`include "ctt_defines.vh"
module ctt_transfer_trap_asserts (
	input wire I_SYS_CLK,
	input wire I_RESET,
	input wire I_OP_VALID,
	input wire [15:0] I_OP_CODE,
	input wire [15:0] I_TRAP_VECTOR,
	input wire O_OP_READY,
	input wire O_DONE,
	input wire O_PUSH_VALID,
	input wire [19:0] O_PUSH_ADDR,
	input wire [15:0] O_ACC_D,
	input wire [15:0] O_ACC_E,
	input wire [35:0] O_MAC,
	input wire [15:0] O_FLAGS,
	input wire [3:0] O_PK,
	input wire [15:0] O_PC,
	input wire [7:0] O_X_MODULO_MASK,
	input wire [7:0] O_Y_MODULO_MASK
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	wire tk = I_OP_VALID && O_OP_READY;
	property p_trap_len;
		tk && I_OP_CODE == `CTT_OP_SOFTWARE_TRAP |-> ##15 !O_DONE ##1 O_DONE;
	endproperty
	a_trap_len: assert property (p_trap_len) else $error("trap length");
	property p_trap_push;
		tk && I_OP_CODE == `CTT_OP_SOFTWARE_TRAP |-> ##2 O_PUSH_VALID ##1
			(O_PUSH_VALID && O_PUSH_ADDR == $past(O_PUSH_ADDR) - 20'h00002);
	endproperty
	a_trap_push: assert property (p_trap_push) else $error("trap push");
	property p_trap_vec;
		tk && I_OP_CODE == `CTT_OP_SOFTWARE_TRAP |->
			##16 O_PK == 4'h0 && O_PC == $past(I_TRAP_VECTOR);
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector");
	property p_widen;
		tk && I_OP_CODE == `CTT_OP_BYTE_SIGN_WIDEN |->
			##2 O_DONE && O_ACC_D[15:8] == {8{O_ACC_D[7]}};
	endproperty
	a_widen: assert property (p_widen) else $error("sign widen");
	property p_mask;
		tk && I_OP_CODE == `CTT_OP_MODULO_MASK_LOAD |-> ##2 O_DONE &&
			{O_X_MODULO_MASK, O_Y_MODULO_MASK} == $past(O_ACC_D, 2) && $stable(O_FLAGS);
	endproperty
	a_mask: assert property (p_mask) else $error("mask load");
	property p_pair;
		tk && I_OP_CODE == `CTT_OP_PAIR_TO_MAC |-> ##4 O_DONE && !O_FLAGS[14]
			&& !O_FLAGS[12] && O_MAC == {{4{O_ACC_E[15]}}, O_ACC_E, O_ACC_D};
	endproperty
	a_pair: assert property (p_pair) else $error("pair to mac");
	property p_high;
		tk && I_OP_CODE == `CTT_OP_HIGH_WORD_TO_MAC |-> ##4 O_DONE &&
			O_MAC == {{4{O_ACC_E[15]}}, O_ACC_E, 16'h0000};
	endproperty
	a_high: assert property (p_high) else $error("high word to mac");
	property p_round;
		tk && I_OP_CODE == `CTT_OP_ROUNDED_MAC_OUT |-> ##5 !O_DONE ##1 O_DONE;
	endproperty
	a_round: assert property (p_round) else $error("rounded mac out");
	property p_move;
		tk && I_OP_CODE == `CTT_OP_A_TO_B |-> ##2 O_DONE && !O_FLAGS[9] &&
			O_FLAGS[10] == (O_ACC_D[7:0] == 8'h00);
	endproperty
	a_move: assert property (p_move) else $error("byte move");
endmodule // ctt_transfer_trap_asserts

bind ctt_transfer_trap ctt_transfer_trap_asserts u_chk (
	.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_OP_VALID(I_OP_VALID),
	.I_OP_CODE(I_OP_CODE), .I_TRAP_VECTOR(I_TRAP_VECTOR),
	.O_OP_READY(O_OP_READY), .O_DONE(O_DONE), .O_PUSH_VALID(O_PUSH_VALID),
	.O_PUSH_ADDR(O_PUSH_ADDR), .O_ACC_D(O_ACC_D), .O_ACC_E(O_ACC_E),
	.O_MAC(O_MAC), .O_FLAGS(O_FLAGS), .O_PK(O_PK), .O_PC(O_PC),
	.O_X_MODULO_MASK(O_X_MODULO_MASK), .O_Y_MODULO_MASK(O_Y_MODULO_MASK));

// File: dv/tb_top.sv
// Self-checking random bench for the transfer and trap unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_top;
	logic clk = 0, rst = 1, vld = 0, rdy, unk, done, pv;
	logic [15:0] code = 16'h0000, vec = 16'h0000, d, e, fl, pc, sp;
	logic [19:0] pa, m_pc = 20'h00000, m_sp = 20'h00000;
	logic [15:0] pd, m_fl = 16'h0000;
	logic [35:0] mac, pq[$];
	logic [3:0] pk, sk, ek, xk, yk, zk;
	logic [7:0] xm, ym;
	int failures = 0, n_tests = 0, seed = 64, k;
	logic [15:0] ops[18] = '{16'h3720, 16'h27f8, 16'h3717, 16'h37fd,
		16'h3707, 16'h27fa, 16'h379f, 16'h379c, 16'h379d, 16'h379e,
		16'h277b, 16'h372f, 16'h372d, 16'h27fb, 16'h27b1, 16'h27bb,
		16'h27b2, 16'h27b4};
	int cyc[18] = '{16, 2, 2, 4, 2, 2, 2, 2, 2, 2, 2, 2, 4, 2, 4, 2, 4, 6};
	ctt_transfer_trap dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_OP_VALID(vld),
		.I_OP_CODE(code), .I_TRAP_VECTOR(vec), .O_OP_READY(rdy),
		.O_OP_UNKNOWN(unk), .O_DONE(done), .O_PUSH_VALID(pv),
		.O_PUSH_ADDR(pa), .O_PUSH_DATA(pd), .O_ACC_D(d), .O_ACC_E(e),
		.O_MAC(mac), .O_FLAGS(fl), .O_PK(pk), .O_PC(pc), .O_SK(sk),
		.O_SP(sp), .O_EK(ek), .O_XK(xk), .O_YK(yk), .O_ZK(zk),
		.O_X_MODULO_MASK(xm), .O_Y_MODULO_MASK(ym));
	always #2 clk = ~clk;
	// Mid-cycle capture avoids racing the registered push outputs
	always @(negedge clk) if (pv === 1'b1) pq.push_back({pa, pd});
	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nf(logic [15:0] op, logic [15:0] f);
		case (op)
		16'h3717, 16'h3707, 16'h277b, 16'h27fb: f[11:9] = 3'b010;
		16'h27f8: f[11:10] = 2'b01;
		16'h27b4: begin
			f[14] = 1'b0;
			f[12] = 1'b0;
			f[11:10] = 2'b01;
		end
		16'h37fd: f[15:8] = 8'h00;
		16'h372d: f[15:4] = 12'h000;
		16'h27b1, 16'h27b2: begin
			f[14] = 1'b0;
			f[12] = 1'b0;
		end
		default: ;
		endcase
		return f;
	endfunction
	task automatic run(input logic [15:0] op, input int n);
		int c;
		logic [35:0] p1, p2;
		vld <= 1'b1;
		code <= op;
		@(posedge clk);
		vld <= 1'b0;
		code <= 16'($random(seed));
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (done !== 1'b1 && c < 40);
		`CHK("cycles", n - 1, c)
		if (op == 16'h3720) begin
			m_pc += 20'h00002;
			m_fl[3:0] = m_pc[19:16];
			p1 = {m_sp, m_pc[15:0]};
			p2 = {m_sp - 20'h00002, m_fl};
			m_sp -= 20'h00004;
			m_fl[3:0] = 4'h0;
			m_pc = {4'h0, vec};
			`CHK("pushes", 2, pq.size())
			if (pq.size() == 2) begin
				`CHK("push pc", p1, pq[0])
				`CHK("push ccw", p2, pq[1])
			end
		end else begin
			`CHK("no push", 0, pq.size())
		end
		// Bank load copies a zero low nibble
		if (op == 16'h379f) m_sp[19:16] = 4'h0;
		m_fl = nf(op, m_fl);
		pq.delete();
		`CHK("flags", m_fl, fl)
		`CHK("pc", m_pc, {pk, pc})
		`CHK("stack", m_sp, {sk, sp})
		`CHK("data", 100'h0, {d, e, mac, xm, ym, ek, xk, yk, zk})
		$display("op %h done", op);
		@(posedge clk);
	endtask
	task wrap_up;
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("ready", 1'b1, rdy)
		// Second trap carries the counter into the bank field
		vec <= 16'hfffe;
		run(ops[0], 16);
		run(ops[0], 16);
		for (int i = 0; i < 18; i++) run(ops[i], cyc[i]);
		vld <= 1'b1;
		code <= 16'h0000;
		@(posedge clk);
		vld <= 1'b0;
		// Pulse stands only in the cycle after the offering edge
		#1;
		`CHK("unknown", 1'b1, unk)
		`CHK("idle", 1'b1, rdy)
		@(posedge clk);
		repeat (60) begin
			k = $unsigned($random(seed)) % 18;
			vec <= 16'($random(seed));
			run(ops[k], cyc[k]);
		end
		wrap_up;
	end
endmodule // tb_top
